// ===== hdl/apt_defines.vh
// Constants for the period timer: register offsets, control field
// positions, reset values and latency counts. Definitions only.
`ifndef APT_DEFINES_VH
`define APT_DEFINES_VH

// Register byte offsets on the AHB-Lite slave.
`define APT_OFF_CONTROL 4'h0
`define APT_OFF_COUNT 4'h4
`define APT_OFF_PERIOD 4'h8
`define APT_OFF_EVENT 4'hc

// Control register field positions.
`define APT_CTL_ON 15
`define APT_CTL_WDIS 12
`define APT_CTL_WIP 11
`define APT_CTL_CKPS_HI 6
`define APT_CTL_CKPS_LO 4
`define APT_CTL_SYNC 2
`define APT_CTL_CS 1

// Event register field positions.
`define APT_EVT_FLAG 0
`define APT_EVT_ENABLE 1

// Reset values.
`define APT_CONTROL_RST 16'h0000
`define APT_COUNT_RST 16'h0000
`define APT_PERIOD_RST 16'hffff

// Control bits software may write; write-pending is read-only.
`define APT_CTL_WMASK 16'h9076

// Timer clock edges a count write or an enable change waits for.
`define APT_SYNC_EDGES 2'h2
// Stages between a period match and the event flag.
`define APT_FLAG_STAGES 3

`endif

// ===== hdl/apt_timer.v
// Period timer with a 16-bit count, prescaler, asynchronous counter mode
// and an AHB-Lite register slave.
// Assumes one clock hclk (the peripheral bus clock, equal to the system
// clock) and external clock inputs that are sampled in the hclk domain.
//
// Functional notes
// - Variant A counts the external clock asynchronously if cs=1, sync=0.
// - Count rises each timer edge, reloads zero after period match.
// - Period zero: count returns to zero and then holds there.
// - Match sets event flag within a few cycles; request only if enabled.
// - Asynchronous mode keeps counting in sleep; match interrupt wakes.
// - Write-block bit 12, write-pending bit 11; inert in sync modes.
// - Write-block 0: write-pending high while a count write synchronises.
// - Write-block 1: writes during synchronisation are discarded.
// - Asynchronous count write lands on the second timer edge after the write.
// - Asynchronous count read lags the live count by 2 bus clocks.
// - Variant A on external clock starts counting 2-3 edges after enable.
// - Variant A prescale 1,8,64,256 from control bits 5:4.
// - Variant B prescale 1,2,4,8,16,32,64,256 from control bits 6:4.
// - Prescaler clears on count write, disable, and non-power-on resets.
// - Clearing enable stops the timer; count keeps its value.
// - Byte writes keep the other byte; low 0xFF carries to high byte.
// - A count write masks the increment in that cycle.
// - Synchronous modes: count reads and writes act immediately.
// - Flag sets one bus clock plus two system clocks after the event.
// - Variant A external clock disable waits 2-3 edges; else immediate.
// - Secondary oscillator clocks variant A when enabled with cs=1.
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "apt_defines.vh"

module apt_timer #(
  parameter SECOND_VARIANT = 0
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Any device reset other than power-on, active low, synchronous.
  input wire sys_reset_n,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // External clock sources.
  input wire timer_external_clock_pin,
  input wire crystal_input_pin,
  input wire sosc_enable,
  output reg crystal_output_pin,
  // Interrupt request, also the wake request in sleep.
  output reg event_irq
);

  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_WAIT = 3'h2;
  localparam [2:0] ST_DONE = 3'h4;

  // Byte lanes touched by an AHB transfer of a given size and address.
  function [31:0] apt_lane_mask;
    input [2:0] size;
    input [1:0] addr;
    begin
      case (size)
        3'h0: apt_lane_mask = 32'h0000_00ff << {addr, 3'h0};
        3'h1: apt_lane_mask = addr[1] ? 32'hffff_0000 : 32'h0000_ffff;
        default: apt_lane_mask = 32'hffff_ffff;
      endcase
    end
  endfunction

  // Last prescaler count for a ratio code, per timer variant.
  function [7:0] apt_pre_last;
    input [2:0] code;
    input variant_b;
    begin
      if (!variant_b) begin
        case (code[1:0])
          2'h0: apt_pre_last = 8'h00;
          2'h1: apt_pre_last = 8'h07;
          2'h2: apt_pre_last = 8'h3f;
          default: apt_pre_last = 8'hff;
        endcase
      end else begin
        case (code)
          3'h0: apt_pre_last = 8'h00;
          3'h1: apt_pre_last = 8'h01;
          3'h2: apt_pre_last = 8'h03;
          3'h3: apt_pre_last = 8'h07;
          3'h4: apt_pre_last = 8'h0f;
          3'h5: apt_pre_last = 8'h1f;
          3'h6: apt_pre_last = 8'h3f;
          default: apt_pre_last = 8'hff;
        endcase
      end
    end
  endfunction

  // Bus state.
  reg [2:0] bus_st_r;
  reg [3:0] bus_addr_r;
  reg bus_write_r;
  reg [31:0] bus_mask_r;

  // Timer state.
  reg [15:0] control_r;
  reg [15:0] count_r;
  reg [15:0] period_r;
  reg flag_r;
  reg flag_en_r;
  reg [7:0] pre_r;
  reg run_r;
  reg [1:0] en_edges_r;
  reg pend_r;
  reg [15:0] pend_val_r;
  reg [1:0] pend_edges_r;
  reg [15:0] rd_d1_r;
  reg [15:0] rd_d2_r;
  reg [`APT_FLAG_STAGES-1:0] match_pipe_r;

  // External clock synchroniser and edge detector.
  reg ext_s1_r;
  reg ext_s2_r;
  reg ext_s3_r;

  wire variant_b = (SECOND_VARIANT != 0);
  wire ctl_on = control_r[`APT_CTL_ON];
  wire ctl_cs = control_r[`APT_CTL_CS];
  wire ctl_sync = control_r[`APT_CTL_SYNC];
  wire ctl_wdis = control_r[`APT_CTL_WDIS];
  wire [2:0] ctl_ckps = control_r[`APT_CTL_CKPS_HI:`APT_CTL_CKPS_LO];

  // Asynchronous counter mode exists on variant A only.
  wire async_mode = !variant_b && ctl_cs && !ctl_sync;
  // Variant A external-clock modes pay the edge latency on enable changes.
  wire slow_enable = !variant_b && ctl_cs;

  // Variant A takes the crystal when the oscillator is on.
  wire ext_src = (!variant_b && sosc_enable) ?
                 crystal_input_pin : timer_external_clock_pin;
  wire ext_edge = ext_s2_r && !ext_s3_r;
  wire src_tick = ctl_cs ? ext_edge : 1'b1;

  // Data-phase write strobes, taken in the first data cycle.
  wire wr_cycle = (bus_st_r == ST_WAIT) && bus_write_r;
  wire wr_ctl = wr_cycle && (bus_addr_r == `APT_OFF_CONTROL);
  wire wr_cnt_bus = wr_cycle && (bus_addr_r == `APT_OFF_COUNT);
  wire wr_per = wr_cycle && (bus_addr_r == `APT_OFF_PERIOD);
  wire wr_evt = wr_cycle && (bus_addr_r == `APT_OFF_EVENT);

  // A write in flight is refused only in write-block mode.
  wire wr_cnt_drop = async_mode && pend_r && ctl_wdis;
  wire wr_cnt = wr_cnt_bus && !wr_cnt_drop;
  wire [15:0] cnt_mask = bus_mask_r[15:0];
  wire [15:0] cnt_merged = (count_r & ~cnt_mask) |
                           (hwdata[15:0] & cnt_mask);
  wire [15:0] ctl_mask = bus_mask_r[15:0] & `APT_CTL_WMASK;

  // Pending asynchronous write lands on the second timer edge.
  wire pend_land = pend_r && ext_edge &&
                   (pend_edges_r == `APT_SYNC_EDGES - 2'h1);

  wire pre_last = (pre_r == apt_pre_last(ctl_ckps, variant_b));
  wire cnt_tick = run_r && src_tick && pre_last && !wr_cnt_bus;
  wire at_period = (count_r == period_r);
  wire wip = async_mode && pend_r;

  // External clock: first flop feeds only the second.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_src;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // AHB-Lite slave: one wait state so hrdata can come from a flop and
  // a read right after a write sees the written value, except after an asynchronous count write.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_r <= ST_IDLE;
      bus_addr_r <= 4'h0;
      bus_write_r <= 1'b0;
      bus_mask_r <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (bus_st_r)
        ST_IDLE, ST_DONE: begin
          if (hsel && htrans[1] && hready) begin
            bus_st_r <= ST_WAIT;
            bus_addr_r <= {haddr[3:2], 2'h0};
            bus_write_r <= hwrite;
            bus_mask_r <= apt_lane_mask(hsize, haddr[1:0]);
            hreadyout <= 1'b0;
          end else begin
            bus_st_r <= ST_IDLE;
            hreadyout <= 1'b1;
          end
        end
        ST_WAIT: begin
          bus_st_r <= ST_DONE;
          hreadyout <= 1'b1;
        end
        default: begin
          bus_st_r <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // Read data; offsets repeat every 16 bytes and reserved bits read zero.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_st_r == ST_WAIT && !bus_write_r) begin
      case (bus_addr_r)
        `APT_OFF_CONTROL: hrdata <= {16'h0000,
            control_r | ({15'h0000, wip} << `APT_CTL_WIP)};
        `APT_OFF_COUNT: hrdata <= {16'h0000,
            async_mode ? rd_d2_r : count_r};
        `APT_OFF_PERIOD: hrdata <= {16'h0000, period_r};
        `APT_OFF_EVENT: hrdata <= {30'h0000_0000, flag_en_r, flag_r};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Control and period registers.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_r <= `APT_CONTROL_RST;
      period_r <= `APT_PERIOD_RST;
    end else if (!sys_reset_n) begin
      control_r <= `APT_CONTROL_RST;
      period_r <= `APT_PERIOD_RST;
    end else begin
      if (wr_ctl)
        control_r <= (control_r & ~ctl_mask) | (hwdata[15:0] & ctl_mask);
      if (wr_per)
        period_r <= (period_r & ~bus_mask_r[15:0]) |
                    (hwdata[15:0] & bus_mask_r[15:0]);
    end
  end

  // Run state: immediate except variant A on an external clock, where
  // both enable and disable wait for two timer edges.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
      en_edges_r <= 2'h0;
    end else if (!sys_reset_n) begin
      run_r <= 1'b0;
      en_edges_r <= 2'h0;
    end else if (!slow_enable || run_r == ctl_on) begin
      run_r <= ctl_on;
      en_edges_r <= 2'h0;
    end else if (ext_edge) begin
      if (en_edges_r == `APT_SYNC_EDGES - 2'h1) begin
        run_r <= ctl_on;
        en_edges_r <= 2'h0;
      end else begin
        en_edges_r <= en_edges_r + 2'h1;
      end
    end
  end

  // Prescaler counter.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_r <= 8'h00;
    end else if (!sys_reset_n || !ctl_on || wr_cnt_bus) begin
      pre_r <= 8'h00;
    end else if (run_r && src_tick) begin
      pre_r <= pre_last ? 8'h00 : pre_r + 8'h01;
    end
  end

  // Pending asynchronous count write. Without write-block a newer write
  // replaces the value in flight; software should poll write-pending.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pend_val_r <= 16'h0000;
      pend_edges_r <= 2'h0;
    end else if (!sys_reset_n) begin
      pend_r <= 1'b0;
      pend_edges_r <= 2'h0;
    end else if (wr_cnt && async_mode) begin
      pend_r <= 1'b1;
      pend_val_r <= cnt_merged;
      pend_edges_r <= 2'h0;
    end else if (pend_land || !async_mode) begin
      pend_r <= 1'b0;
      pend_edges_r <= 2'h0;
    end else if (pend_r && ext_edge) begin
      pend_edges_r <= pend_edges_r + 2'h1;
    end
  end

  // Count register. The count is kept across disable and is only loaded
  // by software or by the period reload; the sleep state plays no part.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= `APT_COUNT_RST;
    end else if (wr_cnt && !async_mode) begin
      count_r <= cnt_merged;
    end else if (pend_land) begin
      count_r <= pend_val_r;
    end else if (cnt_tick) begin
      // A zero period parks the count at zero from the next tick on.
      if (at_period || period_r == 16'h0000)
        count_r <= 16'h0000;
      else
        count_r <= count_r + 16'h0001;
    end
  end

  // Read lag for asynchronous mode.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_d1_r <= 16'h0000;
      rd_d2_r <= 16'h0000;
    end else begin
      rd_d1_r <= count_r;
      rd_d2_r <= rd_d1_r;
    end
  end

  // Match pipeline: a period of zero never raises an event.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      match_pipe_r <= {`APT_FLAG_STAGES{1'b0}};
    end else begin
      match_pipe_r <= {match_pipe_r[`APT_FLAG_STAGES-2:0],
                       cnt_tick && at_period &&
                       (period_r != 16'h0000)};
    end
  end

  // Event flag and enable; set wins over a software clear.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_r <= 1'b0;
      flag_en_r <= 1'b0;
    end else begin
      if (match_pipe_r[`APT_FLAG_STAGES-1])
        flag_r <= 1'b1;
      else if (wr_evt && bus_mask_r[`APT_EVT_FLAG] &&
               hwdata[`APT_EVT_FLAG])
        flag_r <= 1'b0;
      if (wr_evt && bus_mask_r[`APT_EVT_ENABLE])
        flag_en_r <= hwdata[`APT_EVT_ENABLE];
    end
  end

  // Interrupt and crystal drive outputs.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_irq <= 1'b0;
      crystal_output_pin <= 1'b0;
    end else begin
      event_irq <= flag_r && flag_en_r;
      crystal_output_pin <= sosc_enable && !crystal_input_pin;
    end
  end

endmodule // apt_timer

// ===== testbench/apt_timer_assertions.sv
// Checker for the period timer's bus answers and pins.
// Assumes hready is the slave's own hreadyout (single slave).
`timescale 1ns/1ns
module apt_timer_assertions (
  // Clock and resets.
  input wire hclk,
  input wire hresetn,
  input wire sys_reset_n,
  // Bus.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  // Pins.
  input wire crystal_input_pin,
  input wire sosc_enable,
  input wire crystal_output_pin,
  input wire event_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic take;
  logic rd_r;
  logic [2:0] age_r;
  assign take = hsel && htrans[1] && hready;
  // Age since software last wrote the event register; only then may
  // the request fall, since hardware never clears the flag.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_r <= 1'b0;
      age_r <= 3'h0;
    end else begin
      rd_r <= take && !hwrite;
      if ((take && hwrite && haddr[3:0] == 4'hc) || !sys_reset_n)
        age_r <= 3'h0;
      else if (age_r != 3'h7)
        age_r <= age_r + 3'h1;
    end
  end
  AST_OKAY: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  AST_WAIT_ONE: assert property
    (take |=> !hreadyout ##1 hreadyout)
    else $error("transfer not answered after one wait");
  AST_READY_IDLE: assert property
    (!take && hreadyout |=> hreadyout)
    else $error("wait state without a transfer");
  AST_READY_PULSE: assert property (!hreadyout |=> hreadyout)
    else $error("wait state longer than one cycle");
  AST_UPPER_ZERO: assert property (rd_r |=> hrdata[31:16] == 16'h0)
    else $error("upper read lanes not zero");
  AST_XTAL: assert property ($past(hresetn) |->
    crystal_output_pin == $past(sosc_enable && !crystal_input_pin))
    else $error("oscillator drive wrong");
  AST_IRQ_STICKY: assert property
    (event_irq && age_r == 3'h7 && sys_reset_n |=> event_irq)
    else $error("request fell without software");
  AST_RESET_QUIET: assert property
    ($rose(hresetn) |-> !event_irq && hreadyout && !crystal_output_pin)
    else $error("outputs busy after reset");
endmodule // apt_timer_assertions

bind apt_timer apt_timer_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
  .sys_reset_n(sys_reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp),
  .crystal_input_pin(crystal_input_pin), .sosc_enable(sosc_enable),
  .crystal_output_pin(crystal_output_pin), .event_irq(event_irq));

// ===== testbench/apt_ext_source.sv
// Behavioural external clock source for the timer's clock inputs.
// Assumes a half period well above two bus clock cycles.
`timescale 1ns/1ns
module apt_ext_source #(
  parameter int HALF_NS = 86
) (
  // Control.
  input wire logic run,
  // Clock out.
  output logic clk_out
);
  // Edges fall on odd times so none meets a bus clock edge; the line is
  // held low while stopped.
  initial begin
    clk_out = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule // apt_ext_source

// ===== testbench/apt_timer_tb.sv
// Self-checking bench for the period timer over AHB-Lite.
// Assumes one slave, so hready is the slave's hreadyout.
`timescale 1ns/1ns
module apt_timer_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic sys_reset_n = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sosc_enable = 1'b0;
  logic pin_run = 1'b1;
  logic xtal_run = 1'b0;
  logic dph = 1'b0;
  logic dph_rd = 1'b0;
  logic [31:0] rnd = 32'h909dcdae;
  logic [63:0] expq[$];
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire pin_clk;
  wire xtal_clk;
  wire xtal_out;
  wire event_irq;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;

  always #10 hclk = ~hclk;
  apt_ext_source #(.HALF_NS(86)) u_pin (.run(pin_run), .clk_out(pin_clk));
  apt_ext_source #(.HALF_NS(130)) u_xtal (.run(xtal_run), .clk_out(xtal_clk));
  apt_timer u_dut (.hclk(hclk), .hresetn(hresetn), .sys_reset_n(sys_reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .timer_external_clock_pin(pin_clk),
    .crystal_input_pin(xtal_clk), .sosc_enable(sosc_enable),
    .crystal_output_pin(xtal_out), .event_irq(event_irq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One single transfer; every change lands just after a rising edge.
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 3'h2);
  endtask

  // A read notes its expectation before the bus carries it.
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hffffffff);
    expq.push_back({m, e & m});
    xfer(1'b0, a, 32'h0, 3'h2);
  endtask

  // Cycle ceiling: a hang counts as a mismatch and ends the run.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      finish_test();
    end
  end

  // Close a data phase before noting a new address phase, since the two
  // overlap on back-to-back transfers.
  always @(posedge hclk) begin
    logic [63:0] e;
    if (dph && hreadyout) begin
      if (dph_rd) begin
        e = expq.pop_front();
        chk_word(hrdata & e[63:32], e[31:0]);
      end
      dph = 1'b0;
    end
    if (hresetn && hsel && htrans[1] && hreadyout) begin
      dph = 1'b1;
      dph_rd = !hwrite;
    end
  end

  // Main sequence.
  initial begin
    int r;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(32'h0, 32'h0);
    rd(32'h8, 32'hffff);
    rd(32'hc, 32'h0);
    rd(32'h10, 32'h0);
    wr(32'h0, 32'h7fff);
    rd(32'h0, 32'h1076);
    wr(32'h0, 32'h0);
    // Byte writes keep the other byte and carry once running.
    wr(32'h4, 32'h1200);
    xfer(1'b1, 32'h4, 32'h00ff, 3'h0);
    rd(32'h4, 32'h12ff);
    xfer(1'b1, 32'h5, 32'h3400, 3'h0);
    rd(32'h4, 32'h34ff);
    wr(32'h0, 32'h8000);
    repeat (8) @(posedge hclk);
    wr(32'h0, 32'h0);
    rd(32'h4, 32'h3500, 32'hff00);
    sys_reset_n <= 1'b0;
    repeat (2) @(posedge hclk);
    sys_reset_n <= 1'b1;
    @(posedge hclk);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h3500, 32'hff00);
    // Ratios 8, 64 and 256 run 43.5 of their periods and ratio 1 runs 43, so the count sits near 0x2b.
    for (int c = 0; c < 4; c++) begin
      r = (c == 0) ? 1 : (c == 1) ? 8 : (c == 2) ? 64 : 256;
      wr(32'h4, 32'h0);
      wr(32'h0, 32'(c) << 4);
      wr(32'h0, 32'h8000 | 32'(c) << 4);
      repeat (r * 43 + r / 2) @(posedge hclk);
      wr(32'h0, 32'h0);
      rd(32'h4, 32'h28, 32'hfff8);
    end
    // Period zero parks the count at zero and raises no flag.
    rnd = xs(rnd);
    wr(32'h4, {16'h0, rnd[15:0]});
    wr(32'h8, 32'h0);
    wr(32'hc, 32'h2);
    wr(32'h0, 32'h8000);
    repeat (20) @(posedge hclk);
    rd(32'h4, 32'h0);
    rd(32'hc, 32'h2);
    // Period match: reload, flag and request; then mask and clear.
    wr(32'h0, 32'h0);
    wr(32'h4, 32'h0);
    wr(32'h8, 32'h3);
    wr(32'h0, 32'h8000);
    r = 0;
    while (event_irq !== 1'b1 && r < 40) begin
      @(posedge hclk);
      r++;
    end
    chk_word({31'h0, event_irq}, 32'h1);
    wr(32'h0, 32'h0);
    rd(32'h4, 32'h0, 32'hfffc);
    wr(32'hc, 32'h0);
    rd(32'hc, 32'h1);
    wr(32'hc, 32'h1);
    rd(32'hc, 32'h0);
    // Asynchronous count writes: pending bit, landing, then a discard.
    rnd = xs(rnd);
    wr(32'h0, 32'h2);
    wr(32'h4, {16'h0, rnd[15:0]});
    rd(32'h0, 32'h0802);
    repeat (60) @(posedge hclk);
    rd(32'h0, 32'h2);
    rd(32'h4, {16'h0, rnd[15:0]});
    wr(32'h0, 32'h1002);
    wr(32'h4, 32'h01fc);
    wr(32'h4, ~rnd);
    repeat (60) @(posedge hclk);
    rd(32'h4, 32'h01fc);
    // With the pin stopped, only the oscillator can move the count.
    pin_run <= 1'b0;
    sosc_enable <= 1'b1;
    xtal_run <= 1'b1;
    wr(32'h0, 32'h9002);
    repeat (200) @(posedge hclk);
    wr(32'h0, 32'h1002);
    rd(32'h4, 32'h0200, 32'hff00);
    finish_test();
  end
endmodule // apt_timer_tb
